// File: hw/dpdc_pkg.sv
package dpdc_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SWITCH_GAP_DELAY = 8'h16;
  localparam logic [7:0] IDX_MANUAL_BLOCK_POWER_DOWN = 8'h17;
  localparam logic [7:0] IDX_BIAS_AND_POWER_SOURCE_SELECT = 8'h18;
  localparam logic [7:0] IDX_WAFER_TEST_RESERVED = 8'h19;
  localparam int ADDR_W = 8;

  // Byte address is four times the index
  localparam logic [ADDR_W-1:0] ADDR_SWITCH_GAP_DELAY = {IDX_SWITCH_GAP_DELAY[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MANUAL_BLOCK_POWER_DOWN =
    {IDX_MANUAL_BLOCK_POWER_DOWN[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_BIAS_AND_POWER_SOURCE_SELECT =
    {IDX_BIAS_AND_POWER_SOURCE_SELECT[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_WAFER_TEST_RESERVED =
    {IDX_WAFER_TEST_RESERVED[5:0], 2'b00};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SWITCH_GAP_DELAY = 8'h0c;
  localparam logic [7:0] RST_MANUAL_BLOCK_POWER_DOWN = 8'h02;
  localparam logic [7:0] RST_BIAS_AND_POWER_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] RST_WAFER_TEST_RESERVED = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_COLOR_CHANNELS_OFF = 0;
  localparam int BIT_MONO_CHANNEL_OFF = 1;
  localparam int BIT_PLL_OFF = 2;
  localparam int BIT_PHASE_INTERP_OFF = 3;
  localparam int BIT_LOW_REF_BUFFER_OFF = 4;
  localparam int BIT_HIGH_REF_BUFFER_OFF = 5;
  localparam int BIT_BLACK_LEVEL_BUFFER_OFF = 6;
  localparam int BIT_BIAS_BLOCK_OFF = 7;
  localparam int BIT_MONO_BIAS_SELECT = 5;
  localparam int BIT_POWER_SOURCE_SELECT = 7;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode inputs from the video configuration registers
  typedef struct packed {
    logic [1:0] video_input_select;
    logic clock_source_select;
    logic interp_bypass;
  } dpdc_mode_t;

  // Effective power-down controls to the analog blocks
  typedef struct packed {
    logic bias_block_off;
    logic black_level_buffer_off;
    logic high_ref_buffer_off;
    logic low_ref_buffer_off;
    logic phase_interp_off;
    logic pll_off;
    logic mono_channel_off;
    logic color_channels_off;
  } dpdc_pwr_t;

endpackage

// File: hw/dpdc_top.sv
// Functional notes
// - 8-bit switch gap delay, resets 0x0c
// - Source select bit 7, manual or automatic
// - Manual bit 0 powers down color channels
// - Auto: mono selected powers down color
// - Manual bit 1: mono and sync separator off
// - Auto: color selected powers down mono
// - Manual bit 2 powers down the PLL
// - Auto: external clock powers down PLL
// - Manual bit 3 powers down phase interpolator
// - Auto: bypass bit powers down interpolator
// - Manual bits 4-6 disable reference buffers
// - Manual bit 7 stops all bias
// - Reserved bias bits reset to zero
// - Bypass leaves only four coarse phases
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns

module dpdc_top #(
  parameter logic [1:0] MONO_SELECT_CODE = 2'h1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [dpdc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [dpdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mode settings from the video configuration logic
  input wire dpdc_pkg::dpdc_mode_t mode,
  // Analog block controls
  output dpdc_pkg::dpdc_pwr_t power_down,
  output logic sync_separator_off,
  output logic coarse_phase_only,
  output logic [7:0] switch_gap_delay_out,
  output logic mono_bias_select_out
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] switch_gap_delay;
  logic [7:0] manual_block_power_down;
  logic [7:0] bias_and_power_source_select;
  logic [7:0] wafer_test_reserved;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [dpdc_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;
  logic wr_hit;

  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;

  // Address and data are taken in either order, one write in flight
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Next holding and answer state, so the readies can come from flops
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_bvalid = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
    end else if (wr_fire) begin
      next_aw_held = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
    end else if (wr_fire) begin
      next_w_held = 1'b0;
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
    end else if (s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Write readies, low while a write is held or being answered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
    end
  end

  // Write address holding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Write data holding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_byte <= '0;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write address decode
  always_comb begin
    case (aw_addr)
      dpdc_pkg::ADDR_SWITCH_GAP_DELAY,
      dpdc_pkg::ADDR_MANUAL_BLOCK_POWER_DOWN,
      dpdc_pkg::ADDR_BIAS_AND_POWER_SOURCE_SELECT,
      dpdc_pkg::ADDR_WAFER_TEST_RESERVED: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dpdc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? dpdc_pkg::RESP_OKAY : dpdc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  // Switch gap delay register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      switch_gap_delay <= dpdc_pkg::RST_SWITCH_GAP_DELAY;
    end else if (wr_fire && w_lane0 && aw_addr == dpdc_pkg::ADDR_SWITCH_GAP_DELAY) begin
      switch_gap_delay <= w_byte;
    end
  end

  // Manual power-down bits, mono bit set at reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      manual_block_power_down <= dpdc_pkg::RST_MANUAL_BLOCK_POWER_DOWN;
    end else if (wr_fire && w_lane0 &&
                 aw_addr == dpdc_pkg::ADDR_MANUAL_BLOCK_POWER_DOWN) begin
      manual_block_power_down <= w_byte;
    end
  end

  // Bias and source register, reserved bits kept as written
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bias_and_power_source_select <= dpdc_pkg::RST_BIAS_AND_POWER_SOURCE_SELECT;
    end else if (wr_fire && w_lane0 &&
                 aw_addr == dpdc_pkg::ADDR_BIAS_AND_POWER_SOURCE_SELECT) begin
      bias_and_power_source_select <= w_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wafer_test_reserved <= dpdc_pkg::RST_WAFER_TEST_RESERVED;
    end else if (wr_fire && w_lane0 && aw_addr == dpdc_pkg::ADDR_WAFER_TEST_RESERVED) begin
      wafer_test_reserved <= w_byte;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  logic rd_hit;

  logic next_rvalid;

  // One read in flight: next answer state for the registered ready
  always_comb begin
    next_rvalid = s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
    end else if (s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Read ready, low while read data stands
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !next_rvalid;
    end
  end

  // Read address decode
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      dpdc_pkg::ADDR_SWITCH_GAP_DELAY: rd_byte = switch_gap_delay;
      dpdc_pkg::ADDR_MANUAL_BLOCK_POWER_DOWN: rd_byte = manual_block_power_down;
      dpdc_pkg::ADDR_BIAS_AND_POWER_SOURCE_SELECT: rd_byte = bias_and_power_source_select;
      dpdc_pkg::ADDR_WAFER_TEST_RESERVED: rd_byte = wafer_test_reserved;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data, upper bits read as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dpdc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? dpdc_pkg::RESP_OKAY : dpdc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-down source selection
  // ----------------------------------------------------------------
  logic manual_src;
  logic mono_selected;
  dpdc_pkg::dpdc_pwr_t auto_pd;
  dpdc_pkg::dpdc_pwr_t next_power_down;

  // Bit 7 picks manual bits, else mode-derived
  assign manual_src = bias_and_power_source_select[dpdc_pkg::BIT_POWER_SOURCE_SELECT];
  assign mono_selected = (mode.video_input_select == MONO_SELECT_CODE);

  // Automatic conditions from the mode settings
  always_comb begin
    auto_pd = '0;
    auto_pd.color_channels_off = mono_selected;
    auto_pd.mono_channel_off = !mono_selected;
    auto_pd.pll_off = mode.clock_source_select;
    auto_pd.phase_interp_off = mode.interp_bypass;
  end

  // Per-block mux of manual bit versus automatic condition
  always_comb begin
    next_power_down = manual_src ? dpdc_pkg::dpdc_pwr_t'(manual_block_power_down) : auto_pd;
  end

  // Registered block controls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_down <= '0;
      sync_separator_off <= 1'b0;
    end else begin
      power_down <= next_power_down;
      sync_separator_off <= next_power_down.mono_channel_off;
    end
  end

  // Coarse phase only when bypassed or interpolator off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coarse_phase_only <= 1'b0;
    end else begin
      coarse_phase_only <= mode.interp_bypass || next_power_down.phase_interp_off;
    end
  end

  // Switch gap and mono bias drives to the analog side
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      switch_gap_delay_out <= dpdc_pkg::RST_SWITCH_GAP_DELAY;
      mono_bias_select_out <= 1'b0;
    end else begin
      switch_gap_delay_out <= switch_gap_delay;
      mono_bias_select_out <= bias_and_power_source_select[dpdc_pkg::BIT_MONO_BIAS_SELECT];
    end
  end

endmodule // dpdc_top

// File: verif/dpdc_top_sva.sv
`timescale 1ns/1ns

module dpdc_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dpdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mode and block controls
  input wire dpdc_pkg::dpdc_mode_t mode,
  input wire dpdc_pkg::dpdc_pwr_t power_down,
  input wire logic sync_separator_off,
  input wire logic coarse_phase_only
);
  // Read address hits one of the four registers
  logic rd_hit;
  assign rd_hit = s_axi_araddr inside {8'h58, 8'h5c, 8'h60, 8'h64};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_sync_follows_mono: assert property (sync_separator_off == power_down.mono_channel_off)
    else $error("sync separator control differs from mono power-down");
  chk_bypass_coarse: assert property ($past(rst_n) && $past(mode.interp_bypass) |-> coarse_phase_only)
    else $error("bypass did not restrict to coarse phases");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  chk_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during data");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_resp_map: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rresp == ($past(rd_hit) ? dpdc_pkg::RESP_OKAY : dpdc_pkg::RESP_SLVERR))
    else $error("read response code wrong");
endmodule // dpdc_top_sva

// File: verif/tb.sv
`timescale 1ns/1ns

module tb;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  localparam logic [1:0] MONO_CODE = 2'h1;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sep_off, coarse, mbias;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] gap;
  logic [7:0] ra;
  dpdc_pkg::dpdc_mode_t mode = '0;
  dpdc_pkg::dpdc_pwr_t pd;
  int regs[4] = '{8'h0c, 8'h02, 8'h00, 8'h00};
  int err_total = 0;
  int compares = 0;
  int cycles = 0;

  dpdc_top #(.MONO_SELECT_CODE(MONO_CODE)) dpdc_top_inst (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mode(mode), .power_down(pd), .sync_separator_off(sep_off), .coarse_phase_only(coarse),
    .switch_gap_delay_out(gap), .mono_bias_select_out(mbias));

  // Clock and hang limit
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit hit;
    hit = a inside {8'h58, 8'h5c, 8'h60, 8'h64};
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid} <= 2'b11;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!((awready || !awvalid) && (wready || !wvalid)));
    // Late ready, so the response must stand for one edge
    do @(posedge clk); while (!bvalid);
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
    chk("bresp", bresp, hit ? dpdc_pkg::RESP_OKAY : dpdc_pkg::RESP_SLVERR);
    if (hit && s[0]) regs[(a - 8'h58) >> 2] = d[7:0];
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    bit hit;
    hit = a inside {8'h58, 8'h5c, 8'h60, 8'h64};
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    // Late ready, so the read data must stand for one edge
    do @(posedge clk); while (!rvalid);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    chk("rresp", rresp, hit ? dpdc_pkg::RESP_OKAY : dpdc_pkg::RESP_SLVERR);
    chk("rdata", rdata, hit ? regs[(a - 8'h58) >> 2] : 0);
    @(posedge clk);
  endtask

  // Settle, then compare block controls with the model
  task automatic chk_pwr();
    int e;
    repeat (3) @(posedge clk);
    if (regs[2][7]) e = regs[1];
    else e = {mode.interp_bypass, mode.clock_source_select,
              mode.video_input_select != MONO_CODE, mode.video_input_select == MONO_CODE};
    chk("power_down", pd, e);
    chk("sync_sep", sep_off, e[1]);
    chk("coarse", coarse, mode.interp_bypass | e[3]);
    chk("gap_out", gap, regs[0]);
    chk("mono_bias", mbias, regs[2][5]);
  endtask

  task automatic print_verdict();
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h6bcc4688));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_pwr();
    // Reset values and one unmapped place
    for (int i = 0; i < 5; i++) rd(8'h58 + 8'(i * 4));
    // Automatic source over every mode
    for (int i = 0; i < 16; i++) begin
      mode <= 4'(i);
      chk_pwr();
    end
    // Manual source, each bit alone then random
    wr(8'h60, 32'h80, 4'hf);
    for (int i = 0; i < 12; i++) begin
      wr(8'h5c, i < 8 ? 32'(1 << i) : $urandom, 4'h1);
      mode <= 4'($urandom);
      chk_pwr();
    end
    // Random access, strobe off and unmapped included
    for (int i = 0; i < 16; i++) begin
      ra = 8'h58 + 8'(($urandom % 5) * 4);
      wr(ra, ra == 8'h58 ? 32'h0c : $urandom, 4'($urandom));
      rd(8'h58 + 8'(($urandom % 5) * 4));
      mode <= 4'($urandom);
      chk_pwr();
    end
    // Mid-run reset brings every register back
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    regs = '{8'h0c, 8'h02, 8'h00, 8'h00};
    @(posedge clk);
    for (int i = 0; i < 5; i++) rd(8'h58 + 8'(i * 4));
    chk_pwr();
    print_verdict();
  end
endmodule // tb

bind dpdc_top dpdc_top_sva dpdc_top_sva_inst (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mode(mode),
  .power_down(power_down), .sync_separator_off(sync_separator_off),
  .coarse_phase_only(coarse_phase_only));
